// File: rtl/gpm_params.svh
// Purpose: Constants for the generator protection monitor
// Assumes: 100 MHz clk_i, classic Wishbone register access
// Notes: Offsets are byte addresses of 32-bit registers
// Functional notes
// R01 - On load, frequency under warning or shutdown limit raises matching alarm.
// R02 - On load, frequency over warning or shutdown limit raises matching alarm.
// R03 - Frequency fault only after fail timer, 0 to 10 s, default 1 s.
// R04 - Battery under 12.0 V warns, under 9.0 V shuts down.
// R05 - Battery over 29.0 V warns, over 30.0 V shuts down.
// R06 - Battery fault only after battery fail timer, up to 10 s, default 3 s.
// R07 - Phase voltage deviating from average beyond limit flags unbalance; zero disables.
// R08 - Phase current deviating from average beyond limit flags unbalance; zero disables.
// R09 - Unbalance action code: 0 none, 1 shutdown, 2 loaddump, 3 warning.
// R10 - Negative power magnitude over warning limit warns; zero limit disables monitoring.
// R11 - Negative power magnitude over loaddump limit raises loaddump alarm.
// R12 - Reverse power fault only after fail timer, up to 120 s, default 5 s.
// R13 - On load, any phase current over overcurrent limit flags fault; zero disables.
// R14 - Second or third voltage set selects second or third overcurrent limit.
// R15 - Time multiplier 1 to 64, default 16, larger reacts faster.
// R16 - Frequency percent limits are relative to nominal frequency, default 50 Hz.
// R17 - Overcurrent action 1 is loaddump; every other code is shutdown.
// R18 - Fail timers restart from zero when the quantity returns within limits.
`ifndef GPM_PARAMS_SVH
`define GPM_PARAMS_SVH

// Timing
`define GPM_CLK_NS 10
`define GPM_TICK_NS 100000000
`define GPM_TICKS_PER_SEC 10
`define GPM_OC_BASE 65
`define GPM_OC_MULT_MAX 64

// Register byte offsets
`define GPM_OFF_CTRL 8'h00
`define GPM_OFF_NOMF 8'h04
`define GPM_OFF_FLIM 8'h08
`define GPM_OFF_TIMR 8'h0C
`define GPM_OFF_BLOW 8'h10
`define GPM_OFF_BHIG 8'h14
`define GPM_OFF_UNB 8'h18
`define GPM_OFF_REV 8'h1C
`define GPM_OFF_OC12 8'h20
`define GPM_OFF_OC3 8'h24
`define GPM_OFF_STAT 8'h28
`define GPM_OFF_MASK 8'h2C
`define GPM_OFF_LIVE 8'h30
`define GPM_NUM_CFG 10

// Writable bits and reset values per config register
`define GPM_MSK_CTRL 32'h000000FF
`define GPM_RST_CTRL 32'h00000000
`define GPM_MSK_NOMF 32'h000001FF
`define GPM_RST_NOMF 32'h00000032
`define GPM_MSK_FLIM 32'hFFFFFFFF
`define GPM_RST_FLIM 32'h140FECF1
`define GPM_MSK_TIMR 32'h007F7FFF
`define GPM_RST_TIMR 32'h00100531
`define GPM_MSK_BAT 32'h01FF01FF
`define GPM_RST_BLOW 32'h005A0078
`define GPM_RST_BHIG 32'h012C0122
`define GPM_MSK_UNB 32'h00007F7F
`define GPM_MSK_W32 32'hFFFFFFFF
`define GPM_MSK_W16 32'h0000FFFF
`define GPM_RST_ZERO 32'h00000000

// Field positions
`define GPM_CTRL_SET 1:0
`define GPM_CTRL_VACT 3:2
`define GPM_CTRL_IACT 5:4
`define GPM_CTRL_OACT 7:6
`define GPM_TIMR_FREQ 3:0
`define GPM_TIMR_BAT 7:4
`define GPM_TIMR_REV 14:8
`define GPM_TIMR_MULT 22:16
`define GPM_LO16 15:0
`define GPM_HI16 31:16
`define GPM_LO9 8:0
`define GPM_HI9 24:16

// Action codes
`define GPM_ACT_NONE 2'h0
`define GPM_ACT_SD 2'h1
`define GPM_ACT_LD 2'h2
`define GPM_ACT_WARN 2'h3
`define GPM_OACT_LD 2'h1

// Event vector
`define GPM_NUM_TMR 11
`define GPM_NUM_EV 13

`endif

// File: rtl/gpm_pkg.sv
// Purpose: Types shared by the protection monitor files
// Assumes: Constants come from gpm_params.svh
// Notes: Measurements in 0.1 Hz, 0.1 V, volts, amperes, kW
`include "gpm_params.svh"
package gpm_pkg;
	typedef logic [1:0] gpm_action_t;

	// Snapshot from the measurement front end
	typedef struct packed {
		logic [15:0] freq_dhz;
		logic [15:0] vbat_dv;
		logic [2:0][15:0] phase_v;
		logic [2:0][15:0] phase_i;
		logic signed [23:0] power_kw;
	} gpm_meas_t;

	// Alarm levels towards engine stop and load release
	typedef struct packed {
		logic warning;
		logic loaddump;
		logic shutdown;
	} gpm_alarm_t;
endpackage

// File: rtl/gpm_fail_timer.sv
// Purpose: Qualifies one excursion with a fail timer
// Assumes: tick_i is a one-cycle pulse every 100 ms
// Notes: A limit of zero declares the fault on the next edge
`timescale 1ns/1ps
module gpm_fail_timer (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Qualification
	input wire logic tick_i,
	input wire logic cond_i,
	input wire logic [11:0] limit_i,
	output logic fault_o
);
	logic [11:0] cnt_q;

	////////////////////////////////////////////////////////////////
	// Count ticks while out of limits; restart on return
	always_ff @(posedge clk_i) begin
		if (rst_i || !cond_i) begin
			cnt_q <= 12'h000; // R18
		end else if (tick_i && cnt_q < limit_i) begin
			cnt_q <= cnt_q + 12'h001;
		end
	end

	// Fault only once the full time has elapsed
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_o <= 1'b0;
		end else begin
			fault_o <= cond_i && (cnt_q >= limit_i); // R03 R06 R12
		end
	end
endmodule // gpm_fail_timer

// File: rtl/gpm_protection_monitor.sv
// Purpose: Limit checks, fail timers and alarm outputs for a genset
// Assumes: Measurements are synchronous to clk_i and refreshed by the front end
// Notes: Registers over classic Wishbone, one-cycle ack after each request
//
// Register access over Wishbone and the register offsets were decided locally.
`timescale 1ns/1ps
`include "gpm_params.svh"
module gpm_protection_monitor #(
	parameter int TICK_CYCLES = `GPM_TICK_NS / `GPM_CLK_NS
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Measurement front end
	input gpm_pkg::gpm_meas_t meas_i,
	input wire logic gen_on_load_i,
	// Alarm consumers
	output gpm_pkg::gpm_alarm_t alarm_o,
	output logic irq_o
);
	import gpm_pkg::*;

	////////////////////////////////////////////////////////////////
	// Helpers

	// Byte lanes selected by sel, limited to writable bits
	function automatic logic [31:0] lane_mask(input logic [3:0] sel, input logic [31:0] wmask);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return m & wmask;
	endfunction

	// Config register index from byte address, or 15 if none
	function automatic logic [3:0] cfg_index(input logic [7:0] adr);
		logic [3:0] idx;
		idx = 4'hF;
		if (adr[1:0] == 2'h0 && adr < `GPM_OFF_STAT) begin
			idx = adr[5:2];
		end
		return idx;
	endfunction

	// Writable bits of each config register
	function automatic logic [31:0] cfg_wmask(input int idx);
		logic [31:0] m;
		case (idx)
			0: m = `GPM_MSK_CTRL;
			1: m = `GPM_MSK_NOMF;
			2: m = `GPM_MSK_FLIM;
			3: m = `GPM_MSK_TIMR;
			4, 5: m = `GPM_MSK_BAT;
			6: m = `GPM_MSK_UNB;
			7, 8: m = `GPM_MSK_W32;
			9: m = `GPM_MSK_W16;
			default: m = `GPM_RST_ZERO;
		endcase
		return m;
	endfunction

	// Reset value of each config register
	function automatic logic [31:0] cfg_reset(input int idx);
		logic [31:0] r;
		case (idx)
			1: r = `GPM_RST_NOMF;
			2: r = `GPM_RST_FLIM;
			3: r = `GPM_RST_TIMR;
			4: r = `GPM_RST_BLOW;
			5: r = `GPM_RST_BHIG;
			default: r = `GPM_RST_ZERO;
		endcase
		return r;
	endfunction

	// Any phase deviating from the average by more than pct percent
	// |3x - sum| * 100 > pct * sum avoids a divider
	function automatic logic unbalanced(input logic [2:0][15:0] x, input logic [6:0] pct);
		logic signed [31:0] sum;
		logic signed [31:0] dev;
		logic hit;
		sum = 32'(x[0]) + 32'(x[1]) + 32'(x[2]);
		hit = 1'b0;
		for (int k = 0; k < 3; k++) begin
			dev = 32'(3 * 32'(x[k])) - sum;
			if (dev < 0) begin
				dev = -dev;
			end
			if (dev * 32'sd100 > 32'(pct) * sum) begin
				hit = 1'b1;
			end
		end
		return hit && (pct != 7'h00); // R07 R08
	endfunction

	////////////////////////////////////////////////////////////////
	// Register map, one 32-bit word per offset
	// CTRL: set select [1:0], where 0 and 3 both mean the primary set
	//   voltage unbalance action [3:2], current unbalance action [5:4]
	//   overcurrent action [7:6], code 1 loaddump, any other shutdown
	// NOMF: nominal frequency [8:0] in Hz
	// FLIM: signed percent bytes, low warning [7:0], low shutdown [15:8]
	//   high warning [23:16], high shutdown [31:24]
	// TIMR: fail times in seconds, frequency [3:0], battery [7:4]
	//   reverse power [14:8]; overcurrent multiplier [22:16]
	// BLOW: low battery warning [8:0], shutdown [24:16], in 0.1 V
	// BHIG: high battery warning [8:0], shutdown [24:16], in 0.1 V
	// UNB: unbalance percent, voltage [6:0], current [14:8]
	// REV: reverse power warning [15:0], loaddump [31:16], in kW
	//   A zero warning limit switches both reverse power checks off
	// OC12: overcurrent limits of the first [15:0] and second [31:16] set
	// OC3: overcurrent limit of the third set [15:0]
	// STAT: sticky events, write one to clear; MASK has the same layout
	//   timed faults [10:0], current unbalance [11], voltage unbalance [12]
	// LIVE: read only, faults [10:0], current unbalance [14]
	//   voltage unbalance [15], alarm levels [18:16]
	// Unmapped offsets read zero and drop writes, so a stray access
	// can never move a limit
	// The multiplier field needs seven bits, since its top value is 64

	////////////////////////////////////////////////////////////////
	// Declarations
	logic [31:0] cfg_q [0:`GPM_NUM_CFG-1];
	logic [`GPM_NUM_EV-1:0] status_q;
	logic [`GPM_NUM_EV-1:0] mask_q;
	logic [`GPM_NUM_EV-1:0] events;
	logic [31:0] tick_cnt_q;
	logic tick_q;
	logic req;
	logic wr_stb;
	logic [3:0] wr_idx;
	logic [31:0] rd_d;
	logic [31:0] ev_lane;
	logic [`GPM_NUM_TMR-1:0] cond;
	logic [`GPM_NUM_TMR-1:0] fault;
	logic [11:0] tlim [0:`GPM_NUM_TMR-1];
	logic vunb;
	logic iunb;
	logic [15:0] oc_lim;
	logic [23:0] rev_mag;
	gpm_alarm_t alarm_d;

	////////////////////////////////////////////////////////////////
	// Bus handshake: ack one cycle after the request, for one cycle
	// A write lands at the ack edge, while the master still holds its data
	assign req = wb_cyc_i && wb_stb_i;
	assign wr_stb = req && wb_we_i && wb_ack_o;
	assign wr_idx = cfg_index(wb_adr_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req && !wb_ack_o;
		end
	end

	// Read mux; unmapped addresses read as zero
	always_comb begin
		rd_d = 32'h00000000;
		if (wr_idx != 4'hF) begin
			rd_d = cfg_q[wr_idx];
		end else if (wb_adr_i == `GPM_OFF_STAT) begin
			rd_d = 32'(status_q);
		end else if (wb_adr_i == `GPM_OFF_MASK) begin
			rd_d = 32'(mask_q);
		end else if (wb_adr_i == `GPM_OFF_LIVE) begin
			rd_d = {13'h0000, alarm_o, vunb, iunb, 3'h0, fault};
		end
	end

	// Read data captured as the ack is raised
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (req && !wb_ack_o) begin
			wb_dat_o <= rd_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Config registers, written at the edge that ends the cycle
	always_ff @(posedge clk_i) begin
		for (int k = 0; k < `GPM_NUM_CFG; k++) begin
			if (rst_i) begin
				cfg_q[k] <= cfg_reset(k);
			end else if (wr_stb && wr_idx == 4'(k)) begin
				cfg_q[k] <= (cfg_q[k] & ~lane_mask(wb_sel_i, cfg_wmask(k)))
					| (wb_dat_i & lane_mask(wb_sel_i, cfg_wmask(k)));
			end
		end
	end

	// Writable byte lanes of the event-wide registers

	assign ev_lane = lane_mask(wb_sel_i, {{(32 - `GPM_NUM_EV){1'b0}}, {`GPM_NUM_EV{1'b1}}});

	// Interrupt mask
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_q <= '0;
		end else if (wr_stb && wb_adr_i == `GPM_OFF_MASK) begin
			mask_q <= (mask_q & ~ev_lane[`GPM_NUM_EV-1:0])
				| (wb_dat_i[`GPM_NUM_EV-1:0] & ev_lane[`GPM_NUM_EV-1:0]);
		end
	end

	// Sticky status, write one to clear; a live event wins over the clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_q <= '0;
		end else if (wr_stb && wb_adr_i == `GPM_OFF_STAT) begin
			status_q <= (status_q & ~(wb_dat_i[`GPM_NUM_EV-1:0]
				& ev_lane[`GPM_NUM_EV-1:0])) | events;
		end else begin
			status_q <= status_q | events;
		end
	end

	assign irq_o = |(status_q & mask_q);

	////////////////////////////////////////////////////////////////
	// 100 ms time base for all fail timers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_q <= 32'h00000000;
			tick_q <= 1'b0;
		end else if (tick_cnt_q >= 32'(TICK_CYCLES - 1)) begin
			tick_cnt_q <= 32'h00000000;
			tick_q <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h00000001;
			tick_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Limit comparisons
	// Timer index: 0..3 freq lo-w, lo-sd, hi-w, hi-sd; 4..7 battery same order;
	// 8 reverse warning, 9 reverse loaddump, 10 overcurrent
	always_comb begin
		logic signed [31:0] f100;
		logic signed [31:0] thr [0:3];
		f100 = 32'(meas_i.freq_dhz) * 32'sd10;
		thr = '{default: 32'sh00000000};
		for (int k = 0; k < 4; k++) begin
			thr[k] = 32'(cfg_q[1][`GPM_LO9])
				* (32'sd100 + 32'($signed(cfg_q[2][8*k +: 8]))); // R16
		end
		cond[0] = gen_on_load_i && (f100 < thr[0]); // R01
		cond[1] = gen_on_load_i && (f100 < thr[1]); // R01
		cond[2] = gen_on_load_i && (f100 > thr[2]); // R02
		cond[3] = gen_on_load_i && (f100 > thr[3]); // R02
		cond[4] = meas_i.vbat_dv < 16'(cfg_q[4][`GPM_LO9]); // R04
		cond[5] = meas_i.vbat_dv < 16'(cfg_q[4][`GPM_HI9]); // R04
		cond[6] = meas_i.vbat_dv > 16'(cfg_q[5][`GPM_LO9]); // R05
		cond[7] = meas_i.vbat_dv > 16'(cfg_q[5][`GPM_HI9]); // R05
		cond[8] = (cfg_q[7][`GPM_LO16] != 16'h0000) && meas_i.power_kw[23]
			&& (rev_mag > 24'(cfg_q[7][`GPM_LO16])); // R10
		cond[9] = (cfg_q[7][`GPM_LO16] != 16'h0000) && meas_i.power_kw[23]
			&& (rev_mag > 24'(cfg_q[7][`GPM_HI16])); // R11
		cond[10] = 1'b0;
		for (int k = 0; k < 3; k++) begin
			if (meas_i.phase_i[k] > oc_lim) begin
				cond[10] = gen_on_load_i && (oc_lim != 16'h0000); // R13
			end
		end
	end

	assign rev_mag = 24'(-meas_i.power_kw);

	// Overcurrent limit follows the selected nominal voltage set
	always_comb begin
		case (cfg_q[0][`GPM_CTRL_SET])
			2'h1: oc_lim = cfg_q[8][`GPM_HI16]; // R14
			2'h2: oc_lim = cfg_q[9][`GPM_LO16]; // R14
			default: oc_lim = cfg_q[8][`GPM_LO16];
		endcase
	end

	// Fail times in 100 ms ticks
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			tlim[k] = 12'(cfg_q[3][`GPM_TIMR_FREQ]) * 12'(`GPM_TICKS_PER_SEC); // R03
			tlim[k + 4] = 12'(cfg_q[3][`GPM_TIMR_BAT]) * 12'(`GPM_TICKS_PER_SEC); // R06
		end
		tlim[8] = 12'(cfg_q[3][`GPM_TIMR_REV]) * 12'(`GPM_TICKS_PER_SEC); // R12
		tlim[9] = tlim[8];
		// Larger multiplier means a shorter wait; zero acts as one, above the top clamps
		if (cfg_q[3][`GPM_TIMR_MULT] == 7'h00) begin
			tlim[10] = 12'(`GPM_OC_BASE - 1);
		end else if (cfg_q[3][`GPM_TIMR_MULT] > 7'(`GPM_OC_MULT_MAX)) begin
			tlim[10] = 12'(`GPM_OC_BASE - `GPM_OC_MULT_MAX); // R15
		end else begin
			tlim[10] = 12'(`GPM_OC_BASE) - 12'(cfg_q[3][`GPM_TIMR_MULT]); // R15
		end
	end

	////////////////////////////////////////////////////////////////
	// One fail timer per qualified condition
	generate
		for (genvar g = 0; g < `GPM_NUM_TMR; g++) begin : g_tmr
			gpm_fail_timer u_tmr (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.tick_i(tick_q),
				.cond_i(cond[g]),
				.limit_i(tlim[g]),
				.fault_o(fault[g])
			); // R03 R06 R12 R18
		end
	endgenerate

	// Unbalance checks act at once
	// Event order: timed faults, then current and voltage unbalance
	assign vunb = unbalanced(meas_i.phase_v, cfg_q[6][6:0]); // R07
	assign iunb = unbalanced(meas_i.phase_i, cfg_q[6][14:8]); // R08
	assign events = {vunb, iunb, fault};

	////////////////////////////////////////////////////////////////
	// Alarm classification
	// Levels follow the faults; latching is left to the alarm consumers
	always_comb begin
		gpm_action_t va;
		gpm_action_t ia;
		va = vunb ? gpm_action_t'(cfg_q[0][`GPM_CTRL_VACT]) : `GPM_ACT_NONE;
		ia = iunb ? gpm_action_t'(cfg_q[0][`GPM_CTRL_IACT]) : `GPM_ACT_NONE;
		alarm_d.warning = fault[0] || fault[2] || fault[4] || fault[6] || fault[8]
			|| va == `GPM_ACT_WARN || ia == `GPM_ACT_WARN; // R09
		alarm_d.loaddump = fault[9] || va == `GPM_ACT_LD || ia == `GPM_ACT_LD // R09
			|| (fault[10] && cfg_q[0][`GPM_CTRL_OACT] == `GPM_OACT_LD); // R17
		alarm_d.shutdown = fault[1] || fault[3] || fault[5] || fault[7]
			|| va == `GPM_ACT_SD || ia == `GPM_ACT_SD // R09
			|| (fault[10] && cfg_q[0][`GPM_CTRL_OACT] != `GPM_OACT_LD); // R17
	end

	// Registered alarm levels
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			alarm_o <= '0;
		end else begin
			alarm_o <= alarm_d;
		end
	end
endmodule // gpm_protection_monitor

// File: tb/gpm_front_model.sv
// Purpose: Measurement front end that feeds the monitor
// Assumes: The bench calls apply to change what is measured
// Notes: A new snapshot shows one edge later, as a refreshing front end would
`timescale 1ns/1ps
module gpm_front_model
	import gpm_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Towards the monitor
	output gpm_pkg::gpm_meas_t meas_o,
	output logic on_load_o
);
	gpm_meas_t meas_d = '0;
	gpm_meas_t meas_q = '0;
	logic load_d = 1'b0;
	logic load_q = 1'b0;

	// Bench entry; non-blocking so an edge never sees half a change
	task automatic apply(input gpm_meas_t m, input logic ld);
		meas_d <= m;
		load_d <= ld;
	endtask

	// Snapshot refresh
	always @(posedge clk_i) begin
		meas_q <= meas_d;
		load_q <= load_d;
	end
	assign meas_o = meas_q;
	assign on_load_o = load_q;
endmodule // gpm_front_model

// File: tb/gpm_protection_monitor_asserts.sv
// Purpose: Bus and interrupt checks on the monitor ports
// Assumes: Classic Wishbone master that holds requests until ack
// Notes: Alarm timing depends on config, so the bench judges it
`timescale 1ns/1ps
`include "gpm_params.svh"
module gpm_protection_monitor_asserts
	import gpm_pkg::*;
#(
	parameter int TICK_CYCLES = 10
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Front end and alarms
	input gpm_pkg::gpm_meas_t meas_i,
	input wire logic gen_on_load_i,
	input gpm_pkg::gpm_alarm_t alarm_o,
	input wire logic irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic req;
	logic rd_ack;
	logic mask_seen_q;
	////////////////////////////////////////
	// Pending request and read answer
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign rd_ack = wb_ack_o && !wb_we_i;
	// Mask is zero until written, so no interrupt before that
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_seen_q <= 1'b0;
		end else if (wb_ack_o && wb_we_i && wb_adr_i == `GPM_OFF_MASK) begin
			mask_seen_q <= 1'b1;
		end
	end
	////////////////////////////////////////
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	ack_latency_a: assert property (req |=> wb_ack_o)
		else $error("no ack one cycle after request");
	ack_cause_a: assert property (wb_ack_o |-> $past(req))
		else $error("ack without a taken request");
	reset_quiet_a: assert property (@(posedge clk_i) disable iff (1'b0)
		rst_i |=> !wb_ack_o && alarm_o == 3'h0 && !irq_o && wb_dat_o == 32'h0)
		else $error("outputs not quiet after reset");
	unmapped_zero_a: assert property (rd_ack && wb_adr_i >= 8'h34 |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	reserved_zero_a: assert property (rd_ack && wb_adr_i >= 8'h28 && wb_adr_i != `GPM_OFF_LIVE
		|-> wb_dat_o[31:13] == 19'h0)
		else $error("unused status bits not zero");
	live_spare_a: assert property (rd_ack && wb_adr_i == `GPM_OFF_LIVE
		|-> wb_dat_o[31:19] == 13'h0 && wb_dat_o[13:11] == 3'h0)
		else $error("unused live bits not zero");
	rdata_hold_a: assert property (!req |=> $stable(wb_dat_o))
		else $error("read data moved without request");
	irq_masked_a: assert property (!mask_seen_q |-> !irq_o)
		else $error("interrupt with mask never set");
endmodule // gpm_protection_monitor_asserts

bind gpm_protection_monitor gpm_protection_monitor_asserts #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
	.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
	.wb_dat_o, .wb_ack_o, .meas_i, .gen_on_load_i, .alarm_o, .irq_o
);

// File: tb/gpm_protection_monitor_tb_top.sv
// Purpose: Self-checking bench for the protection monitor
// Assumes: Tick of 10 clocks, so one second is 100 clocks
// Notes: Each step holds a measurement, then checks alarm_o
`timescale 1ns/1ps
`include "gpm_params.svh"
module gpm_protection_monitor_tb_top;
	import gpm_pkg::*;
	localparam logic [2:0] W = 3'h4;
	localparam logic [2:0] L = 3'h2;
	localparam logic [2:0] S = 3'h1;
	localparam logic [2:0] ACT [4] = '{3'h0, S, L, W};
	localparam logic [2:0] OCX [6] = '{S, 3'h0, 3'h0, S, L, S};
	localparam logic [31:0] RV [10] = '{`GPM_RST_CTRL, `GPM_RST_NOMF, `GPM_RST_FLIM, `GPM_RST_TIMR,
		`GPM_RST_BLOW, `GPM_RST_BHIG, 32'h0, 32'h0, 32'h0, 32'h0};
	logic clk_i, rst_i, cyc, stb, we, ack, irq, load;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, rd;
	gpm_meas_t meas, m;
	gpm_alarm_t alarm;
	int error_cnt, checks_done;
	////////////////////////////////////////
	// Clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// Design with a short tick
	gpm_protection_monitor #(.TICK_CYCLES(10)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .meas_i(meas),
		.gen_on_load_i(load), .alarm_o(alarm), .irq_o(irq)
	);
	gpm_front_model i_fe (.clk_i(clk_i), .meas_o(meas), .on_load_o(load));
	////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// Classic cycle; waits for ack, no assumed latency
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		check({31'h0, ack}, 32'h1);
	endtask
	// Hold frequency, battery and load for n clocks, then check alarms
	task automatic step(input int f, input int v, input logic ld, input int n, input logic [2:0] exp);
		m.freq_dhz = 16'(f);
		m.vbat_dv = 16'(v);
		i_fe.apply(m, ld);
		repeat (n) @(posedge clk_i);
		#1 check({29'h0, alarm}, {29'h0, exp});
	endtask
	task automatic end_of_test();
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Watchdog; the tests need about 61 us
	initial begin
		#300000;
		error_cnt++;
		end_of_test();
	end
	////////////////////////////////////////
	initial begin
		error_cnt = 0;
		checks_done = 0;
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h0;
		sel = 4'hF;
		wdat = 32'h0;
		m = '0;
		m.phase_v = {3{16'h0E6}};
		m.phase_i = {3{16'h032}};
		step(500, 240, 0, 11, 3'h0);
		@(posedge clk_i);
		rst_i <= 1'b0;
		// Reset values, then an unmapped read
		for (int k = 0; k < 10; k++) begin
			wb(1'b0, 8'(4 * k), 32'h0);
			check(rd, RV[k]);
		end
		wb(1'b0, 8'h40, 32'h0);
		check(rd, 32'h0);
		// Frequency limits around 50 Hz, fail timer 1 s
		step(424, 240, 1, 80, 3'h0);
		step(424, 240, 1, 40, W);
		step(500, 240, 1, 5, 3'h0);
		step(425, 240, 1, 150, 3'h0);
		step(400, 240, 1, 150, W);
		step(399, 240, 1, 150, W | S);
		step(575, 240, 1, 150, 3'h0);
		step(600, 240, 1, 150, W);
		step(601, 240, 1, 150, W | S);
		step(601, 240, 0, 150, 3'h0);
		// Battery limits, fail timer 3 s
		step(500, 115, 0, 270, 3'h0);
		step(500, 115, 0, 70, W);
		step(500, 240, 0, 5, 3'h0);
		step(500, 115, 0, 200, 3'h0);
		step(500, 240, 0, 3, 3'h0);
		step(500, 115, 0, 200, 3'h0);
		step(500, 90, 0, 340, W);
		step(500, 89, 0, 340, W | S);
		step(500, 290, 0, 340, 3'h0);
		step(500, 301, 0, 340, W | S);
		step(500, 300, 0, 340, W);
		// Reverse power, fail timer 5 s
		wb(1'b1, `GPM_OFF_REV, 32'h0064_0032);
		m.power_kw = -24'sh00003C;
		step(500, 240, 0, 450, 3'h0);
		step(500, 240, 0, 100, W);
		m.power_kw = -24'sh000096;
		step(500, 240, 0, 560, W | L);
		wb(1'b1, `GPM_OFF_REV, 32'h0064_0000);
		step(500, 240, 0, 20, 3'h0);
		m.power_kw = 24'sh0;
		// Unbalance with every action code
		wb(1'b1, `GPM_OFF_UNB, 32'h0000_0A0A);
		for (int k = 0; k < 8; k++) begin
			wb(1'b1, `GPM_OFF_CTRL, 32'(k % 4) << (k < 4 ? 2 : 4));
			m.phase_v[0] = k < 4 ? 16'h12C : 16'h0E6;
			m.phase_i[0] = k < 4 ? 16'h032 : 16'h050;
			step(500, 240, 0, 5, ACT[k % 4]);
		end
		wb(1'b1, `GPM_OFF_UNB, 32'h0);
		step(500, 240, 0, 5, 3'h0);
		// Overcurrent per voltage set and action, multiplier 64
		wb(1'b1, `GPM_OFF_OC12, 32'h00C8_0064);
		wb(1'b1, `GPM_OFF_OC3, 32'h0000_012C);
		wb(1'b1, `GPM_OFF_TIMR, 32'h0040_0531);
		m.phase_i = {3{16'h096}};
		for (int k = 0; k < 6; k++) begin
			wb(1'b1, `GPM_OFF_CTRL, k < 4 ? 32'(k) : 32'(k * 64 - 192));
			step(500, 240, 1, 40, OCX[k]);
		end
		// Default multiplier 16 reacts far slower
		wb(1'b1, `GPM_OFF_CTRL, 32'h0);
		m.phase_i = {3{16'h032}};
		step(500, 240, 1, 5, 3'h0);
		wb(1'b1, `GPM_OFF_TIMR, `GPM_RST_TIMR);
		m.phase_i = {3{16'h096}};
		step(500, 240, 1, 400, 3'h0);
		step(500, 240, 1, 150, S);
		step(500, 240, 0, 5, 3'h0);
		m.phase_i = {3{16'h032}};
		step(500, 240, 0, 5, 3'h0);
		// Sticky status, mask and clear
		wb(1'b0, `GPM_OFF_STAT, 32'h0);
		check(rd, 32'h0000_1FFF);
		#1 check({31'h0, irq}, 32'h0);
		wb(1'b1, `GPM_OFF_STAT, 32'h0000_1FFF);
		wb(1'b0, `GPM_OFF_STAT, 32'h0);
		check(rd, 32'h0);
		wb(1'b1, `GPM_OFF_MASK, 32'h0000_0010);
		step(500, 115, 0, 340, W);
		wb(1'b0, `GPM_OFF_LIVE, 32'h0);
		check(rd, 32'h0004_0010);
		wb(1'b1, `GPM_OFF_STAT, 32'h0000_0010);
		#1 check({31'h0, irq}, 32'h1);
		step(500, 240, 0, 5, 3'h0);
		wb(1'b1, `GPM_OFF_STAT, 32'h0000_0010);
		#1 check({31'h0, irq}, 32'h0);
		end_of_test();
	end
endmodule // gpm_protection_monitor_tb_top
